//--- sacc_pkg.sv
// package of constants and types for the converter control block
package sacc_pkg;
  localparam int RES_W = 10;
  localparam int CH_W = 5;
  localparam int REF_W = 2;
  localparam int TRG_W = 3;
  localparam int PS_W = 3;
  localparam int NUM_SE_CH = 11;
  localparam int CYC_NORMAL = 13;
  localparam int CYC_FIRST = 25;
  localparam int CNT_W = 5;
  // channel codes
  localparam logic [4:0] CH_DIFF_FIRST = 5'h0B;
  localparam logic [4:0] CH_DIFF_LAST = 5'h1A;
  localparam logic [4:0] CH_TEMP = 5'h1B;
  localparam logic [4:0] CH_INTERNAL_CURRENT_SOURCE = 5'h1C;
  // reference source encodings
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_EXT_PIN = 2'h1;
  localparam logic [1:0] REF_INT_LOW = 2'h2;
  localparam logic [1:0] REF_INT_HIGH = 2'h3;
  // trigger source codes; code 0 is the converter's own completion event
  localparam logic [2:0] TRG_SELF = 3'h0;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [4:0] CNT_RESET = 5'h00;
  typedef enum logic [2:0] {
    SACC_IDLE = 3'b001,
    SACC_WAIT = 3'b010,
    SACC_CONV = 3'b100
  } sacc_state_t;
endpackage

//--- sacc_edge.sv
// two-flop synchroniser with rising edge detector for one trigger input
`timescale 1ns/1ps
module sacc_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic s1_d;
  logic s2_d;
  logic s3_d;
  // next values of the sync chain
  always_comb begin
    s1_d = din;
    s2_d = s1_q;
    s3_d = s2_q;
  end
  // register stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end
  assign rise = s2_q & ~s3_q;
endmodule

//--- sacc_top.sv
// conversion control for a 10-bit successive approximation converter
// Operation
// - current source enable bit drives source
// - result is 10-bit unsigned code
// - reference chosen by select and pin enable
// - channel select; single ended bypasses gain
// - differential codes decode 8x or 20x
// - temperature and current point have codes
// - selections applied only while enabled
// - right adjust default, left when set
// - low byte read blocks data updates
// - blocked completion discards the result
// - high byte read lifts the block
// - completion flags even when result discarded
// - start bit set until hardware clears
// - channel locked during running conversion
// - auto trigger only when enabled, selected
// - trigger rising edge resets prescaler, starts
// - held trigger level starts nothing
// - edges during conversion are ignored
// - trigger flags set regardless of enables
// - self trigger restarts regardless of flag
// - software start works with auto trigger
// - conversion lasts 13, first 25 cycles
// - prescaler held reset while disabled
`timescale 1ns/1ps
module sacc_top #(
  parameter int NTRIG = 8
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CONVERTER_ENABLE,
  input wire logic CURRENT_SOURCE_ENABLE,
  input wire logic EXT_REF_PIN_ENABLE,
  input wire logic [sacc_pkg::REF_W-1:0] REF_SELECT,
  input wire logic [sacc_pkg::CH_W-1:0] CHANNEL_SELECT,
  input wire logic LEFT_ADJUST,
  input wire logic AUTO_TRIGGER_ENABLE,
  input wire logic [sacc_pkg::TRG_W-1:0] TRIGGER_SOURCE_SELECT,
  input wire logic [NTRIG-1:0] TRIGGER_IN,
  input wire logic [sacc_pkg::PS_W-1:0] PRESCALE,
  input wire logic START_WRITE,
  input wire logic DONE_FLAG_CLEAR,
  input wire logic LOW_BYTE_READ,
  input wire logic HIGH_BYTE_READ,
  input wire logic CORE_DONE,
  input wire logic [sacc_pkg::RES_W-1:0] CORE_RESULT,
  output logic INTERNAL_CURRENT_SOURCE,
  output logic ANALOG_POWER,
  output logic [sacc_pkg::REF_W-1:0] REF_PATH,
  output logic EXT_REF_PATH,
  output logic [sacc_pkg::CH_W-1:0] CHANNEL_PATH,
  output logic GAIN_BYPASS,
  output logic GAIN_HIGH,
  output logic TEMP_SENSE_SEL,
  output logic INTERNAL_CURRENT_SOURCE_SENSE_SEL,
  output logic SAMPLE_START,
  output logic START_CONVERSION,
  output logic CONVERSION_DONE_FLAG,
  output logic [7:0] RESULT_HIGH_BYTE,
  output logic [7:0] RESULT_LOW_BYTE,
  output logic DATA_BLOCKED
);
  import sacc_pkg::*;

  sacc_state_t st_q, st_d;
  logic [7:0] ps_q, ps_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic first_q, first_d;
  logic sc_q, sc_d;
  logic flag_q, flag_d;
  logic blk_q, blk_d;
  logic [7:0] hi_q, hi_d, lo_q, lo_d;
  logic [REF_W-1:0] ref_q, ref_d;
  logic eref_q, eref_d;
  logic [CH_W-1:0] ch_q, ch_d;
  logic internal_current_source_q, en_q, bypass_q, gainh_q, temp_q, isp_q, samp_q, samp_d;
  logic [NTRIG-1:0] rise;
  logic [NTRIG-1:0] trig_raw;
  logic adc_tick, trig_evt, done_evt, self_evt, sel_ok;
  logic [15:0] left_w, right_w;

  // fresh edge needed to retrigger
  // synchronise each external trigger source and detect its edges
  genvar gi;
  generate
    for (gi = 0; gi < NTRIG; gi++) begin : g_trig
      sacc_edge u_edge (
        .clk(CLOCK),
        .rst_n(RSTN),
        .din(TRIGGER_IN[gi]),
        .rise(rise[gi])
      );
    end
  endgenerate
  assign trig_raw = rise;

  // converter clock tick; compare by >= so a lowered ratio never wraps the count
  assign adc_tick = (ps_q >= ((8'h01 << PRESCALE) - 8'h01));
  assign done_evt = (st_q == SACC_CONV) && adc_tick && (cnt_q == CNT_W'(1));
  assign self_evt = AUTO_TRIGGER_ENABLE && (TRIGGER_SOURCE_SELECT == TRG_SELF) && done_evt;
  // gate auto trigger by enable and select
  assign trig_evt = CONVERTER_ENABLE && AUTO_TRIGGER_ENABLE &&
                    (TRIGGER_SOURCE_SELECT != TRG_SELF) &&
                    trig_raw[TRIGGER_SOURCE_SELECT];
  assign sel_ok = (st_q != SACC_CONV) || done_evt;
  assign right_w = {6'h00, CORE_RESULT};
  assign left_w = {CORE_RESULT, 6'h00};

  // sequencer and prescaler next state
  always_comb begin
    st_d = st_q;
    ps_d = adc_tick ? 8'h00 : ps_q + 8'h01;
    cnt_d = cnt_q;
    first_d = first_q;
    sc_d = sc_q;
    samp_d = 1'b0;
    if (!CONVERTER_ENABLE) begin
      ps_d = 8'h00;
      st_d = SACC_IDLE;
      first_d = 1'b1;
      sc_d = 1'b0;
      cnt_d = CNT_RESET;
    end else begin
      case (st_q)
        SACC_IDLE: begin
          if (trig_evt) begin
            ps_d = 8'h00;
            sc_d = 1'b1;
            st_d = SACC_WAIT;
          end else if (START_WRITE) begin
            sc_d = 1'b1;
            st_d = SACC_WAIT;
          end
        end
        SACC_WAIT: begin
          if (adc_tick) begin
            cnt_d = first_q ? CNT_W'(CYC_FIRST) : CNT_W'(CYC_NORMAL);
            first_d = 1'b0;
            samp_d = 1'b1;
            st_d = SACC_CONV;
          end
        end
        SACC_CONV: begin
          if (adc_tick) begin
            cnt_d = cnt_q - CNT_W'(1);
          end
          if (done_evt) begin
            if (self_evt) begin
              cnt_d = CNT_W'(CYC_NORMAL);
              samp_d = 1'b1;
            end else begin
              sc_d = 1'b0;
              st_d = SACC_IDLE;
            end
          end
        end
        default: begin
          st_d = SACC_IDLE;
        end
      endcase
    end
  end

  // result bytes, block and flag next values
  always_comb begin
    hi_d = hi_q;
    lo_d = lo_q;
    blk_d = blk_q;
    flag_d = flag_q;
    if (LOW_BYTE_READ) begin
      blk_d = 1'b1;
    end
    if (HIGH_BYTE_READ) begin
      blk_d = 1'b0;
    end
    if (DONE_FLAG_CLEAR) begin
      flag_d = 1'b0;
    end
    if (done_evt && CORE_DONE) begin
      flag_d = 1'b1;
      if (!blk_q) begin
        hi_d = LEFT_ADJUST ? left_w[15:8] : right_w[15:8];
        lo_d = LEFT_ADJUST ? left_w[7:0] : right_w[7:0];
      end
    end
  end

  // analog path selection next values
  always_comb begin
    ref_d = ref_q;
    eref_d = eref_q;
    ch_d = ch_q;
    if (CONVERTER_ENABLE && sel_ok) begin
      ref_d = REF_SELECT;
      eref_d = EXT_REF_PIN_ENABLE;
      ch_d = CHANNEL_SELECT;
    end
  end

  // state registers
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      st_q <= SACC_IDLE;
      ps_q <= 8'h00;
      cnt_q <= CNT_RESET;
      first_q <= 1'b1;
      sc_q <= 1'b0;
      flag_q <= 1'b0;
      blk_q <= 1'b0;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      ref_q <= REF_SUPPLY;
      eref_q <= 1'b0;
      ch_q <= 5'h00;
      samp_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ps_q <= ps_d;
      cnt_q <= cnt_d;
      first_q <= first_d;
      sc_q <= sc_d;
      flag_q <= flag_d;
      blk_q <= blk_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      ref_q <= ref_d;
      eref_q <= eref_d;
      ch_q <= ch_d;
      samp_q <= samp_d;
    end
  end

  // decoded analog controls, registered
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      internal_current_source_q <= 1'b0;
      en_q <= 1'b0;
      bypass_q <= 1'b1;
      gainh_q <= 1'b0;
      temp_q <= 1'b0;
      isp_q <= 1'b0;
    end else begin
      internal_current_source_q <= CURRENT_SOURCE_ENABLE;
      en_q <= CONVERTER_ENABLE;
      bypass_q <= (ch_d < CH_DIFF_FIRST) || (ch_d > CH_DIFF_LAST);
      // pair codes with bit 3 set use 20x
      gainh_q <= (ch_d >= CH_DIFF_FIRST) && (ch_d <= CH_DIFF_LAST) && ch_d[3];
      temp_q <= (ch_d == CH_TEMP);
      isp_q <= (ch_d == CH_INTERNAL_CURRENT_SOURCE);
    end
  end

  assign INTERNAL_CURRENT_SOURCE = internal_current_source_q;
  assign ANALOG_POWER = en_q;
  assign REF_PATH = ref_q;
  assign EXT_REF_PATH = eref_q;
  assign CHANNEL_PATH = ch_q;
  assign GAIN_BYPASS = bypass_q;
  assign GAIN_HIGH = gainh_q;
  assign TEMP_SENSE_SEL = temp_q;
  assign INTERNAL_CURRENT_SOURCE_SENSE_SEL = isp_q;
  assign SAMPLE_START = samp_q;
  assign START_CONVERSION = sc_q;
  assign CONVERSION_DONE_FLAG = flag_q;
  assign RESULT_HIGH_BYTE = hi_q;
  assign RESULT_LOW_BYTE = lo_q;
  assign DATA_BLOCKED = blk_q;

  property p_done_together;
    @(posedge CLOCK) disable iff (!RSTN)
      (done_evt && CORE_DONE && !self_evt) |=> (flag_q && !sc_q);
  endproperty
  a_done_together: assert property (p_done_together) else $error("flag/start mismatch");

  property p_blocked_hold;
    @(posedge CLOCK) disable iff (!RSTN)
      (blk_q && !HIGH_BYTE_READ) |=> ($stable(hi_q) && $stable(lo_q));
  endproperty
  a_blocked_hold: assert property (p_blocked_hold) else $error("blocked data changed");

  property p_flag_discard;
    @(posedge CLOCK) disable iff (!RSTN)
      (done_evt && CORE_DONE && blk_q) |=> flag_q;
  endproperty
  a_flag_discard: assert property (p_flag_discard) else $error("flag missed");

  property p_low_blocks;
    @(posedge CLOCK) disable iff (!RSTN)
      (LOW_BYTE_READ && !HIGH_BYTE_READ) |=> blk_q;
  endproperty
  a_low_blocks: assert property (p_low_blocks) else $error("no block");

  property p_high_lifts;
    @(posedge CLOCK) disable iff (!RSTN)
      HIGH_BYTE_READ |=> !blk_q;
  endproperty
  a_high_lifts: assert property (p_high_lifts) else $error("block kept");

  property p_ps_off;
    @(posedge CLOCK) disable iff (!RSTN)
      !CONVERTER_ENABLE |=> (ps_q == 8'h00 && !sc_q);
  endproperty
  a_ps_off: assert property (p_ps_off) else $error("prescaler ran");

  property p_ch_lock;
    @(posedge CLOCK) disable iff (!RSTN)
      (st_q == SACC_CONV && !done_evt) |=> $stable(ch_q);
  endproperty
  a_ch_lock: assert property (p_ch_lock) else $error("channel moved");

  property p_sc_busy;
    @(posedge CLOCK) disable iff (!RSTN)
      (st_q != SACC_IDLE) |-> sc_q;
  endproperty
  a_sc_busy: assert property (p_sc_busy) else $error("start bit low when busy");

  property p_first_len;
    @(posedge CLOCK) disable iff (!RSTN)
      (st_q == SACC_WAIT && adc_tick && first_q && CONVERTER_ENABLE) |=> (cnt_q == 5'h19);
  endproperty
  a_first_len: assert property (p_first_len) else $error("first length wrong");
endmodule

//--- sacc_core_model.sv
// behavioural model of the sampling core behind the control block
`timescale 1ns/1ps
module sacc_core_model (
  input wire logic clk,
  input wire logic sample_start,
  input wire logic busy,
  input wire logic [sacc_pkg::RES_W-1:0] next_code,
  output logic core_done,
  output logic [sacc_pkg::RES_W-1:0] core_result
);
  import sacc_pkg::*;
  logic [RES_W-1:0] held_q = '0;
  logic live_q = 1'b0;
  always @(posedge clk) begin
    if (sample_start) begin
      held_q <= next_code;
      live_q <= 1'b1;
    end else if (!busy) begin
      live_q <= 1'b0;
    end
  end
  // outside a conversion the result lines show the inverse of the last code
  assign core_done = live_q;
  assign core_result = live_q ? held_q : ~held_q;
endmodule

//--- test_sacc_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_sacc_top;
  import sacc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0, cs = 1'b0, xr = 1'b0, la = 1'b0, ate = 1'b0;
  logic sw = 1'b0, fc = 1'b0, rl = 1'b0, rh = 1'b0;
  logic [1:0] rs = 2'h0;
  logic [4:0] ch = 5'h00;
  logic [2:0] ts = 3'h0, ps = 3'h0;
  logic [7:0] trg = 8'h00;
  logic [9:0] code = 10'h000, prev;
  logic cd, internal_current_source, ap, xp, gb, gh, tsel, isel, ss, sc, flag, blk;
  logic [9:0] cr;
  logic [1:0] rp;
  logic [4:0] chp;
  logic [7:0] hi, lo;
  int miscompares = 0, total_checks = 0, d1, d2, n;
  // clock of 5 ns period
  always #2.5 clk = ~clk;
  sacc_top #(.NTRIG(8)) dut_u (
    .CLOCK(clk), .RSTN(rst_n), .CONVERTER_ENABLE(en), .CURRENT_SOURCE_ENABLE(cs),
    .EXT_REF_PIN_ENABLE(xr), .REF_SELECT(rs), .CHANNEL_SELECT(ch), .LEFT_ADJUST(la),
    .AUTO_TRIGGER_ENABLE(ate), .TRIGGER_SOURCE_SELECT(ts), .TRIGGER_IN(trg), .PRESCALE(ps),
    .START_WRITE(sw), .DONE_FLAG_CLEAR(fc), .LOW_BYTE_READ(rl), .HIGH_BYTE_READ(rh),
    .CORE_DONE(cd), .CORE_RESULT(cr), .INTERNAL_CURRENT_SOURCE(internal_current_source), .ANALOG_POWER(ap),
    .REF_PATH(rp), .EXT_REF_PATH(xp), .CHANNEL_PATH(chp), .GAIN_BYPASS(gb), .GAIN_HIGH(gh),
    .TEMP_SENSE_SEL(tsel), .INTERNAL_CURRENT_SOURCE_SENSE_SEL(isel), .SAMPLE_START(ss), .START_CONVERSION(sc),
    .CONVERSION_DONE_FLAG(flag), .RESULT_HIGH_BYTE(hi), .RESULT_LOW_BYTE(lo),
    .DATA_BLOCKED(blk)
  );
  sacc_core_model core_u (
    .clk(clk), .sample_start(ss), .busy(sc), .next_code(code), .core_done(cd),
    .core_result(cr)
  );
  // compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // wait edges, then step off the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  // expected byte pair for a code and alignment
  function automatic logic [15:0] pack(input logic [9:0] r, input logic l);
    return l ? {r, 6'h00} : {6'h00, r};
  endfunction
  // run out a conversion under a bounded wait
  task automatic finish_conv(output int d);
    d = 0;
    while (sc === 1'b1 && d < 2000) begin
      cyc(1);
      d++;
    end
    chk({sc, flag}, 2'h1);
  endtask
  task automatic conv(output int d);
    pulse(fc);
    pulse(sw);
    chk({sc, flag}, 2'h2);
    finish_conv(d);
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog, far beyond the expected run length
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'h981454B9));
    cyc(16);
    rst_n = 1'b1;
    cyc(4);
    chk({gb, ap, sc, flag, chp}, 9'h100);
    ch = 5'h1B;
    rs = 2'h2;
    cyc(3);
    chk({ap, rp, chp}, 8'h00);
    cs = 1'b1;
    cyc(3);
    chk(internal_current_source, 1'b1);
    cs = 1'b0;
    cyc(3);
    chk(internal_current_source, 1'b0);
    en = 1'b1;
    for (int c = 0; c < 29; c++) begin
      ch = c[4:0];
      rs = 2'($urandom);
      xr = 1'($urandom);
      cyc(3);
      chk({ap, rp, xp, chp}, {1'b1, rs, xr, ch});
      if (c < 27) chk({gb, gh}, {c < 11, c >= 11 && c[3]});
      chk({tsel, isel}, {c == 27, c == 28});
    end
    $display("test paths done");
    ch = 5'h03;
    code = 10'($urandom);
    conv(d1);
    chk({hi, lo}, pack(code, 1'b0));
    la = 1'b1;
    code = 10'h3FF;
    conv(d2);
    chk({hi, lo}, pack(code, 1'b1));
    chk(16'(d1 - d2), 16'h000C);
    $display("test single done");
    ps = 3'($urandom_range(2));
    prev = code;
    pulse(rl);
    chk(blk, 1'b1);
    code = 10'($urandom);
    pulse(fc);
    pulse(sw);
    // wait past the first converter tick so the conversion has begun
    cyc(6);
    ch = 5'h07;
    cyc(2);
    chk({sc, flag, chp}, 7'h43);
    finish_conv(n);
    chk({hi, lo}, pack(prev, 1'b1));
    pulse(rh);
    chk(blk, 1'b0);
    conv(n);
    chk({hi, lo, chp}, {pack(code, 1'b1), 5'h07});
    $display("test block done");
    ps = 3'h0;
    ts = 3'h1;
    trg[1] = 1'b1;
    cyc(6);
    chk(sc, 1'b0);
    trg[1] = 1'b0;
    ate = 1'b1;
    ts = 3'h2;
    cyc(2);
    trg[1] = 1'b1;
    cyc(6);
    chk(sc, 1'b0);
    trg[1] = 1'b0;
    ts = 3'h1;
    pulse(fc);
    cyc(2);
    trg[1] = 1'b1;
    cyc(5);
    chk(sc, 1'b1);
    trg[1] = 1'b0;
    cyc(2);
    trg[1] = 1'b1;
    finish_conv(n);
    cyc(8);
    chk(sc, 1'b0);
    chk({sc, ss}, 2'h0);
    trg[1] = 1'b0;
    code = 10'($urandom);
    conv(n);
    chk({hi, lo}, pack(code, 1'b1));
    $display("test trigger done");
    ts = TRG_SELF;
    la = 1'b0;
    pulse(sw);
    n = 0;
    repeat (60) begin
      n += int'(ss);
      if (sc !== 1'b1) n -= 100;
      cyc(1);
    end
    chk(n > 3, 1'b1);
    ate = 1'b0;
    finish_conv(n);
    chk({hi, lo}, pack(code, 1'b0));
    $display("test free running done");
    cyc(2);
    finish_test();
  end
endmodule
